// >>> design/pst_pkg.sv
package pst_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [15:0] SIM_BASE   = 16'hf0e0;
    localparam logic [15:0] SEL_OFFSET = 16'h0018;
    localparam logic [15:0] SEL_ADDR   = SIM_BASE + SEL_OFFSET;
    localparam logic [15:0] SEL_RESET  = 16'h0000;
    // Reserved odd bits 11..1 never store
    localparam logic [15:0] SEL_WMASK  = 16'hf555;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int TIMER_B_CH3_INPUT_SELECT_BIT = 15;
    localparam int TIMER_B_CH2_INPUT_SELECT_BIT = 14;
    localparam int TIMER_B_CH1_INPUT_SELECT_BIT = 13;
    localparam int TIMER_B_CH0_INPUT_SELECT_BIT = 12;
    localparam int E7_BIT    = 10;
    localparam int E6_BIT    = 8;
    localparam int E5_BIT    = 6;
    localparam int E4_BIT    = 4;
    localparam int F8_BIT    = 2;
    localparam int A0_BIT    = 0;

    // ****************************************************************
    // Pad indices
    // ****************************************************************
    localparam int PAD_F7  = 0;
    localparam int PAD_F6  = 1;
    localparam int PAD_F8  = 2;
    localparam int PAD_C2  = 3;
    localparam int PAD_E7  = 4;
    localparam int PAD_E6  = 5;
    localparam int PAD_E5  = 6;
    localparam int PAD_E4  = 7;
    localparam int PAD_A0  = 8;
    localparam int NPAD    = 9;
    localparam int NDIG    = 8;

    // Serial receive idles high while the pad is not routed
    localparam logic RX_IDLE = 1'b1;

    // Pad owned by the function that the select value names
    function automatic logic owns(input logic en,
                                  input logic sel,
                                  input logic want);
        owns = en & (sel == want);
    endfunction

endpackage

// >>> design/pst_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pst_reg_if;
    logic        wr_stb;
    logic [15:0] wr_data;
    logic [15:0] rd_data;

    modport bus (
        output wr_stb,
        output wr_data,
        input  rd_data
    );
    modport core (
        input  wr_stb,
        input  wr_data,
        output rd_data
    );
endinterface
`default_nettype wire

// >>> design/pst_sync3.sv
`timescale 1ns/10ps
`default_nettype none
module pst_sync3 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Change taken only once stages two and three agree
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sync <= '0;
        end else begin
            o_sync <= (s2_r & s3_r) | (o_sync & (s2_r | s3_r));
        end
    end
endmodule
`default_nettype wire

// >>> design/pst_avmm_slave.sv
`timescale 1ns/10ps
`default_nettype none
module pst_avmm_slave (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic [15:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    pst_reg_if.bus           reg_bus
);
    logic req;
    logic hit;
    logic [15:0] lane_mask;

    assign req       = i_avs_read | i_avs_write;
    assign hit       = (i_avs_address == pst_pkg::SEL_ADDR); // RQ1
    assign lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

    // ****************************************************************
    // One wait state, then the answer edge
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= ~(req & o_avs_waitrequest);
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && o_avs_waitrequest) begin
            o_avs_readdata <= hit ? {16'h0000, reg_bus.rd_data} : '0;
        end
    end

    // Merge keeps unselected byte lanes
    assign reg_bus.wr_stb  = i_avs_write & ~o_avs_waitrequest & hit;
    assign reg_bus.wr_data = (i_avs_writedata[15:0] & lane_mask)
                           | (reg_bus.rd_data & ~lane_mask);
endmodule
`default_nettype wire

// >>> design/pst_top.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// RQ1 - Select register answers at base 0xf0e0 plus offset 0x18.
// RQ2 - Single-function pins need no field; function follows enable bit.
// RQ3 - Each timer B field picks pad or crossbar output as input.
// RQ4 - Software enables the pad and routes it when a pad feeds timer B.
// RQ5 - Bit 15: timer B3 from port F pin 7 or crossbar output 29.
// RQ6 - Bit 14: timer B2 from port F pin 6 or crossbar output 28.
// RQ7 - Bit 13: timer B1 from port F pin 8 or crossbar output 27.
// RQ8 - Bit 12: timer B0 from port C pin 2 or crossbar output 26.
// RQ9 - Bit 10: E7 is PWM3 A both ways, or crossbar input 5.
// RQ10 - Bit 8: E6 is PWM3 B both ways, or crossbar input 4.
// RQ11 - Bit 6: E5 is PWM2 A both ways, or crossbar input 3.
// RQ12 - Bit 4: E4 is PWM2 B both ways, or crossbar input 2.
// RQ13 - Bit 2: F8 is serial 0 receive, or timer B channel 1 both ways.
// RQ14 - Bit 0: A0 is analog ADC/comparator A, or drives comparator C out.
// RQ15 - Odd bits 11 down to 1 are read-only zero.
// RQ16 - Fields clear on reset; reserved-bit writes are ignored.
module pst_top (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic [15:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [3:0]  i_avs_byteenable,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [8:0]  i_pad_function_enable,
    input  wire logic [7:0]  i_pad_in,
    output logic      [8:0]  o_pad_out,
    output logic      [8:0]  o_pad_oe,
    input  wire logic [3:0]  i_crossbar_output,
    output logic      [3:0]  o_crossbar_input,
    input  wire logic [3:0]  i_pwm_out,
    input  wire logic [3:0]  i_pwm_oe,
    output logic      [3:0]  o_pwm_in,
    input  wire logic        i_timer_b_ch1_out,
    input  wire logic        i_timer_b_ch1_oe,
    output logic      [3:0]  o_timer_b_input,
    output logic             o_serial0_receive,
    input  wire logic        i_comparator_c_output,
    output logic             o_adc_a0_analog_en,
    output logic      [15:0] o_select_value
);
    logic [15:0] sel_r;
    logic [7:0]  pad_s;
    logic [8:0]  en;
    pst_reg_if   rif ();

    // ****************************************************************
    // Register access
    // ****************************************************************
    pst_avmm_slave u_bus (
        .i_clk             (i_clk),
        .i_rstn            (i_rstn),
        .i_avs_address     (i_avs_address),
        .i_avs_read        (i_avs_read),
        .i_avs_write       (i_avs_write),
        .i_avs_byteenable  (i_avs_byteenable),
        .i_avs_writedata   (i_avs_writedata),
        .o_avs_readdata    (o_avs_readdata),
        .o_avs_waitrequest (o_avs_waitrequest),
        .reg_bus           (rif.bus)
    );

    assign rif.rd_data = sel_r;
    assign en          = i_pad_function_enable;

    // Reserved bits masked off so they can never read back as one
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sel_r <= pst_pkg::SEL_RESET; // RQ16
        end else if (rif.wr_stb) begin
            sel_r <= rif.wr_data & pst_pkg::SEL_WMASK; // RQ15 RQ16
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_select_value <= pst_pkg::SEL_RESET;
        end else begin
            o_select_value <= sel_r;
        end
    end

    // ****************************************************************
    // Pad inputs
    // ****************************************************************
    // Pads are asynchronous; adds four cycles of input latency
    pst_sync3 #(
        .W (pst_pkg::NDIG)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async (i_pad_in),
        .o_sync  (pad_s)
    );

    // ****************************************************************
    // Timer B input selection
    // ****************************************************************
    // Pad path relies on software enabling and routing the pad
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_timer_b_input <= '0;
        end else begin
            o_timer_b_input[3] <= sel_r[pst_pkg::TIMER_B_CH3_INPUT_SELECT_BIT]
                                ? i_crossbar_output[3]
                                : pad_s[pst_pkg::PAD_F7]; // RQ3 RQ5 RQ4
            o_timer_b_input[2] <= sel_r[pst_pkg::TIMER_B_CH2_INPUT_SELECT_BIT]
                                ? i_crossbar_output[2]
                                : pad_s[pst_pkg::PAD_F6]; // RQ3 RQ6
            o_timer_b_input[1] <= sel_r[pst_pkg::TIMER_B_CH1_INPUT_SELECT_BIT]
                                ? i_crossbar_output[1]
                                : pad_s[pst_pkg::PAD_F8]; // RQ3 RQ7
            o_timer_b_input[0] <= sel_r[pst_pkg::TIMER_B_CH0_INPUT_SELECT_BIT]
                                ? i_crossbar_output[0]
                                : pad_s[pst_pkg::PAD_C2]; // RQ3 RQ8
        end
    end

    // ****************************************************************
    // Port E pins: PWM or crossbar input
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pwm_in <= '0;
        end else begin
            o_pwm_in[3] <= pst_pkg::owns(en[pst_pkg::PAD_E7],
                               sel_r[pst_pkg::E7_BIT], 1'b0)
                         & pad_s[pst_pkg::PAD_E7]; // RQ9
            o_pwm_in[2] <= pst_pkg::owns(en[pst_pkg::PAD_E6],
                               sel_r[pst_pkg::E6_BIT], 1'b0)
                         & pad_s[pst_pkg::PAD_E6]; // RQ10
            o_pwm_in[1] <= pst_pkg::owns(en[pst_pkg::PAD_E5],
                               sel_r[pst_pkg::E5_BIT], 1'b0)
                         & pad_s[pst_pkg::PAD_E5]; // RQ11
            o_pwm_in[0] <= pst_pkg::owns(en[pst_pkg::PAD_E4],
                               sel_r[pst_pkg::E4_BIT], 1'b0)
                         & pad_s[pst_pkg::PAD_E4]; // RQ12
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_crossbar_input <= '0;
        end else begin
            o_crossbar_input[3] <= pst_pkg::owns(en[pst_pkg::PAD_E7],
                                       sel_r[pst_pkg::E7_BIT], 1'b1)
                                 & pad_s[pst_pkg::PAD_E7]; // RQ9
            o_crossbar_input[2] <= pst_pkg::owns(en[pst_pkg::PAD_E6],
                                       sel_r[pst_pkg::E6_BIT], 1'b1)
                                 & pad_s[pst_pkg::PAD_E6]; // RQ10
            o_crossbar_input[1] <= pst_pkg::owns(en[pst_pkg::PAD_E5],
                                       sel_r[pst_pkg::E5_BIT], 1'b1)
                                 & pad_s[pst_pkg::PAD_E5]; // RQ11
            o_crossbar_input[0] <= pst_pkg::owns(en[pst_pkg::PAD_E4],
                                       sel_r[pst_pkg::E4_BIT], 1'b1)
                                 & pad_s[pst_pkg::PAD_E4]; // RQ12
        end
    end

    // ****************************************************************
    // Serial receive on port F pin 8
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_serial0_receive <= pst_pkg::RX_IDLE;
        end else if (pst_pkg::owns(en[pst_pkg::PAD_F8],
                         sel_r[pst_pkg::F8_BIT], 1'b0)) begin
            o_serial0_receive <= pad_s[pst_pkg::PAD_F8]; // RQ13
        end else begin
            o_serial0_receive <= pst_pkg::RX_IDLE;
        end
    end

    // ****************************************************************
    // Analog path on port A pin 0
    // ****************************************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_adc_a0_analog_en <= 1'b0;
        end else begin
            o_adc_a0_analog_en <= pst_pkg::owns(en[pst_pkg::PAD_A0],
                                      sel_r[pst_pkg::A0_BIT], 1'b0); // RQ14
        end
    end

    // ****************************************************************
    // Pad drivers
    // ****************************************************************
    // Inputs-only pads (F7, F6, C2) never drive
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pad_out <= '0;
        end else begin
            o_pad_out[pst_pkg::PAD_F7] <= 1'b0;
            o_pad_out[pst_pkg::PAD_F6] <= 1'b0;
            o_pad_out[pst_pkg::PAD_C2] <= 1'b0;
            o_pad_out[pst_pkg::PAD_E7] <= i_pwm_out[3]; // RQ9
            o_pad_out[pst_pkg::PAD_E6] <= i_pwm_out[2]; // RQ10
            o_pad_out[pst_pkg::PAD_E5] <= i_pwm_out[1]; // RQ11
            o_pad_out[pst_pkg::PAD_E4] <= i_pwm_out[0]; // RQ12
            o_pad_out[pst_pkg::PAD_F8] <= i_timer_b_ch1_out; // RQ13
            o_pad_out[pst_pkg::PAD_A0] <= i_comparator_c_output; // RQ14
        end
    end

    // Enables gated by function enable so GPIO keeps the pad otherwise
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pad_oe <= '0;
        end else begin
            o_pad_oe[pst_pkg::PAD_F7] <= 1'b0;
            o_pad_oe[pst_pkg::PAD_F6] <= 1'b0;
            o_pad_oe[pst_pkg::PAD_C2] <= 1'b0;
            o_pad_oe[pst_pkg::PAD_E7] <= i_pwm_oe[3]
                & pst_pkg::owns(en[pst_pkg::PAD_E7],
                      sel_r[pst_pkg::E7_BIT], 1'b0); // RQ9
            o_pad_oe[pst_pkg::PAD_E6] <= i_pwm_oe[2]
                & pst_pkg::owns(en[pst_pkg::PAD_E6],
                      sel_r[pst_pkg::E6_BIT], 1'b0); // RQ10
            o_pad_oe[pst_pkg::PAD_E5] <= i_pwm_oe[1]
                & pst_pkg::owns(en[pst_pkg::PAD_E5],
                      sel_r[pst_pkg::E5_BIT], 1'b0); // RQ11
            o_pad_oe[pst_pkg::PAD_E4] <= i_pwm_oe[0]
                & pst_pkg::owns(en[pst_pkg::PAD_E4],
                      sel_r[pst_pkg::E4_BIT], 1'b0); // RQ12
            o_pad_oe[pst_pkg::PAD_F8] <= i_timer_b_ch1_oe
                & pst_pkg::owns(en[pst_pkg::PAD_F8],
                      sel_r[pst_pkg::F8_BIT], 1'b1); // RQ13
            o_pad_oe[pst_pkg::PAD_A0] <= pst_pkg::owns(en[pst_pkg::PAD_A0],
                      sel_r[pst_pkg::A0_BIT], 1'b1); // RQ14 RQ2
        end
    end

endmodule
`default_nettype wire

// >>> sim/pst_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Peripherals, crossbar and pad wires seen from the select block
// ****************************************************************
module pst_far_side (
    input  wire logic        i_clk,
    input  wire logic [14:0] i_src,
    input  wire logic [7:0]  i_ext,
    input  wire logic [8:0]  i_pad_out,
    input  wire logic [8:0]  i_pad_oe,
    output logic      [7:0]  o_pad_in,
    output logic      [14:0] o_drv
);
    // Peripheral levels change just after an edge, like real flops
    always_ff @(posedge i_clk) begin
        o_drv <= i_src;
    end
    // Pad wire: the block's drive wins, else the outside world
    assign o_pad_in = (i_pad_oe[7:0] & i_pad_out[7:0])
                    | (~i_pad_oe[7:0] & i_ext);
endmodule
`default_nettype wire

// >>> sim/pst_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pst_monitor (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic [15:0] i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [8:0]  i_pad_function_enable,
    input wire logic [8:0]  o_pad_oe,
    input wire logic [3:0]  i_crossbar_output,
    input wire logic [3:0]  i_pwm_oe,
    input wire logic [3:0]  o_timer_b_input,
    input wire logic        o_adc_a0_analog_en,
    input wire logic [15:0] o_select_value
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // ****************************************************************
    // Guards; $past(i_rstn) skips the first edge out of reset
    // ****************************************************************
    a_timer_b_ch3_input_select_crossbar_switch: assert property ($past(i_rstn) && o_select_value[15]
        |-> o_timer_b_input[3] == $past(i_crossbar_output[3]))
        else $error("timer b3 not from crossbar");
    a_timer_b_ch2_input_select_crossbar_switch: assert property ($past(i_rstn) && o_select_value[14]
        |-> o_timer_b_input[2] == $past(i_crossbar_output[2]))
        else $error("timer b2 not from crossbar");
    a_timer_b_ch1_input_select_crossbar_switch: assert property ($past(i_rstn) && o_select_value[13]
        |-> o_timer_b_input[1] == $past(i_crossbar_output[1]))
        else $error("timer b1 not from crossbar");
    a_timer_b_ch0_input_select_crossbar_switch: assert property ($past(i_rstn) && o_select_value[12]
        |-> o_timer_b_input[0] == $past(i_crossbar_output[0]))
        else $error("timer b0 not from crossbar");
    a_resv_bits_zero: assert property (
        ((o_select_value | o_avs_readdata[15:0]) & 16'h0aaa) == 16'h0000)
        else $error("reserved bit seen as one");
    a_wait_one_cycle: assert property (
        !o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_answer: assert property (
        (i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest)
        else $error("request not answered");
    a_write_stores: assert property (i_avs_write && !o_avs_waitrequest
        && i_avs_address == 16'hf0f8 && i_avs_byteenable[1:0] == 2'b11
        |=> ##1 o_select_value == ($past(i_avs_writedata[15:0], 2)
        & 16'hf555))
        else $error("select value not stored");
    a_e7_pwm_drive: assert property ($past(i_rstn)
        && $past(i_pad_function_enable[4])
        |-> o_pad_oe[4] == (!o_select_value[10] && $past(i_pwm_oe[3])))
        else $error("pad e7 enable wrong");
    a_a0_mode: assert property ($past(i_rstn)
        && $past(i_pad_function_enable[8])
        |-> o_adc_a0_analog_en == !o_select_value[0]
        && o_pad_oe[8] == o_select_value[0])
        else $error("pad a0 mode wrong");
endmodule
bind pst_top pst_monitor pst_monitor_i (.i_clk, .i_rstn, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_byteenable, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .i_pad_function_enable, .o_pad_oe,
    .i_crossbar_output, .i_pwm_oe, .o_timer_b_input, .o_adc_a0_analog_en,
    .o_select_value);
`default_nettype wire

// >>> sim/pst_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pst_top_bench;
    localparam logic [15:0] REG_A = 16'hf0e0 + 16'h0018;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [3:0]  be = 4'h0;
    // Byte lanes used by the next bus call; both lanes unless a test says
    logic [3:0]  bel = 4'h3;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wreq;
    logic [8:0]  en = 9'h000;
    logic [8:0]  pout;
    logic [8:0]  poe;
    logic [7:0]  ext = 8'h00;
    logic [7:0]  pin;
    logic [14:0] src = 15'h0000;
    logic [14:0] drv;
    logic [3:0]  xin;
    logic [3:0]  pwm_in;
    logic [3:0]  tmr;
    logic        ser;
    logic        ana;
    logic [15:0] selv;
    logic [15:0] got;
    int          error_cnt = 0;
    int          n_tests = 0;

    always #20 clk = ~clk;

    pst_far_side pst_far_side_i (.i_clk(clk), .i_src(src), .i_ext(ext),
        .i_pad_out(pout), .i_pad_oe(poe), .o_pad_in(pin), .o_drv(drv));
    pst_top pst_top_i (.i_clk(clk), .i_rstn(rstn), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be),
        .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_pad_function_enable(en),
        .i_pad_in(pin), .o_pad_out(pout), .o_pad_oe(poe),
        .i_crossbar_output(drv[3:0]), .o_crossbar_input(xin),
        .i_pwm_out(drv[7:4]), .i_pwm_oe(drv[11:8]), .o_pwm_in(pwm_in),
        .i_timer_b_ch1_out(drv[12]), .i_timer_b_ch1_oe(drv[13]),
        .o_timer_b_input(tmr), .o_serial0_receive(ser),
        .i_comparator_c_output(drv[14]), .o_adc_a0_analog_en(ana),
        .o_select_value(selv));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {16'h0000, d};
        be <= bel;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        got = rdata[15:0];
        if (n >= 20) error_cnt++;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input logic [14:0] s, input logic [7:0] x,
                       input logic [8:0] e);
        @(posedge clk);
        src <= s;
        ext <= x;
        en <= e;
    endtask
    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        bus(0, REG_A, 16'h0000);
        chk("reset_val", 32'h0, got);
        chk("rx_idle", 32'h1, ser);
        bus(1, REG_A, 16'hffff);
        bus(0, REG_A, 16'h0000);
        chk("reserved", 32'hf555, got);
        chk("sel_copy", 32'hf555, selv);
        bel = 4'h1;
        bus(1, REG_A, 16'h0000);
        bel = 4'h3;
        bus(0, REG_A, 16'h0000);
        chk("byte_lane", 32'hf500, got);
        bus(1, 16'hf0f6, 16'h0000);
        bus(0, 16'hf0f6, 16'h0000);
        chk("unmapped", 32'h0, got);
        bus(0, REG_A, 16'h0000);
        chk("kept", 32'hf500, got);
        @(posedge clk);
        rstn <= 1'b0;
        wt(2);
        rstn <= 1'b1;
        bus(0, REG_A, 16'h0000);
        chk("rereset", 32'h0, got);
    endtask
    task automatic t_timer;
        put(15'h0009, 8'h00, 9'h1ff);
        bus(1, REG_A, 16'hf000);
        wt(3);
        chk("tmr_crossbar_switch", 32'h9, tmr);
        put(15'h0006, 8'h00, 9'h1ff);
        wt(3);
        chk("tmr_xbar2", 32'h6, tmr);
        put(15'h0009, 8'h03, 9'h1ff);
        bus(1, REG_A, 16'h0000);
        wt(8);
        chk("tmr_pad", 32'hc, tmr);
    endtask
    task automatic t_epads;
        put(15'h0350, 8'h60, 9'h1ff);
        wt(8);
        chk("e_oe", 32'hc, poe[7:4]);
        chk("e_out", 32'h8, pout[7:4] & poe[7:4]);
        chk("pwm_in", 32'h5, pwm_in);
        bus(1, REG_A, 16'h0550);
        wt(8);
        chk("e_oe_x", 32'h0, poe[7:4]);
        chk("crossbar_switch_in", 32'h6, xin);
        chk("pwm_in_x", 32'h0, pwm_in);
        put(15'h0350, 8'h60, 9'h00f);
        bus(1, REG_A, 16'h0000);
        wt(8);
        chk("e_off", 32'h0, poe[7:4]);
    endtask
    task automatic t_f8a0;
        put(15'h6000, 8'h00, 9'h1ff);
        wt(8);
        chk("rx_pad", 32'h0, ser);
        chk("a0_analog", 32'h1, ana);
        chk("a0_oe", 32'h0, poe[8]);
        bus(1, REG_A, 16'h0005);
        wt(8);
        chk("f8_oe", 32'h1, poe[2]);
        chk("rx_gated", 32'h1, ser);
        chk("a0_comp", 32'h3, {poe[8], pout[8]});
        chk("a0_digital", 32'h0, ana);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_timer();
        t_epads();
        t_f8a0();
        complete_run();
    end
    // Whole run is about 120 cycles; this bound leaves ample margin
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
